//--- hdl/scx_core.sv
// System-control instruction executor and processing-state sequencer.
// Assumes a fetcher that offers the word at pc_value and a 32-bit memory bus.
`timescale 1ns/100ps
`default_nettype none

module scx_core
	import scx_pkg::*;
#(
	parameter int OSC_CYC = OSC_STAB_CYC
) (
	input wire logic core_clk, // System clock, 100 MHz.
	input wire logic rst_b, // Power-on clear pin, active low.
	input wire logic instr_valid, // Instruction word offered.
	input wire logic [15:0] instr_word, // Instruction at pc_value.
	input wire scx_pkg::scx_mem_rsp_t mem_rsp, // Memory acknowledge and read data.
	input wire scx_pkg::scx_irq_t irq_pins, // Interrupt request pins.
	input wire logic standby_select_bit, // Standby select from low_power_control_reg.
	input wire logic mult_busy, // Multiplier still working.
	output scx_pkg::scx_mem_req_t mem_cmd, // Memory request.
	output scx_pkg::scx_proc_t proc_state, // Processing state.
	output logic [31:0] pc_value, // Program counter.
	output logic [31:0] status_word, // Status word, bit 0 is the test flag.
	output logic instr_ready, // Instruction may be taken.
	output logic instr_done, // Instruction finished.
	output logic irq_ack, // Interrupt taken.
	output logic sleep_mode, // CPU halted, peripherals run.
	output logic standby_mode, // CPU, peripherals and oscillator halted.
	output logic mac_uncertain // Accumulator halves undefined.
);
	//------------------------------------------------------------
	// Declarations and reset release
	//------------------------------------------------------------
	scx_state_t s, n;
	scx_irq_t irq_s;
	logic [1:0] rsync_r;
	logic rst_s;
	logic take, irq_ok, a_we, a_need;
	logic [31:0] a_addr, a_wd, sp, npc;
	logic [1:0] a_last;
	logic [3:0] r;
	logic [2:0] cc, cs;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rsync_r <= 2'b00;
		end else begin
			rsync_r <= {rsync_r[0], 1'b1};
		end
	end
	assign rst_s = rsync_r[1];

	// Interrupt pins cross into the core clock.
	scx_sync #(.WIDTH($bits(scx_irq_t))) u_irq_sync (
		.core_clk(core_clk),
		.rst_b(rst_s),
		.d(irq_pins),
		.q(irq_s)
	);

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_s);

	//------------------------------------------------------------
	// Control register access
	//------------------------------------------------------------
	// Reads one control or system register by index.
	function automatic logic [31:0] ctl_rd(scx_state_t st, logic [2:0] i);
		case (i)
			CR_STATUS: return st.stat;
			CR_GLOBAL: return st.gbase;
			CR_VECTOR: return st.vbase;
			CR_ACC_HI: return st.acc_hi;
			CR_ACC_LO: return st.acc_lo;
			default: return st.link;
		endcase
	endfunction

	// Writes one control or system register by index.
	function automatic scx_state_t ctl_wr(scx_state_t st, logic [2:0] i, logic [31:0] v);
		case (i)
			CR_STATUS: st.stat = v;
			CR_GLOBAL: st.gbase = v;
			CR_VECTOR: st.vbase = v;
			CR_ACC_HI: begin
				st.acc_hi = v;
				st.macu = 1'b0;
			end
			CR_ACC_LO: begin
				st.acc_lo = v;
				st.macu = 1'b0;
			end
			default: st.link = v;
		endcase
		return st;
	endfunction

	// Starts a multi-cycle sequence.
	function automatic scx_state_t seq_go(scx_state_t st, scx_seq_t k, logic [3:0] mn, logic [3:0] rr,
		logic [2:0] i);
		st.ps = PS_SEQ;
		st.seq = k;
		st.step = 2'd0;
		st.cyc = 4'h1;
		st.mfin = 1'b0;
		st.minc = mn;
		st.rn = rr;
		st.idx = i;
		st.ins = 1'b1;
		return st;
	endfunction

	// Starts exception processing with a vector and return address.
	function automatic scx_state_t exc_go(scx_state_t st, logic [7:0] v, logic [31:0] ret, logic [3:0] mn,
		logic ins);
		st = seq_go(st, SQ_EXC, mn, 4'h0, 3'h0);
		st.vec = v;
		st.tmp = ret;
		st.ins = ins;
		st.slot = 1'b0;
		st.proc = PROC_EXC;
		return st;
	endfunction

	//------------------------------------------------------------
	// Next-state logic
	//------------------------------------------------------------
	// Sequencer, decoder and memory handshake.
	always_comb begin
		n = s;
		n.done = 1'b0;
		n.iack = 1'b0;
		take = 1'b0;
		sp = s.gpr[SP_IDX];
		npc = s.slot ? s.slot_pc : s.pc + INSTR_BYTES;
		r = instr_word[11:8];
		cc = {1'b0, instr_word[5:4]};
		cs = CR_ACC_HI + {1'b0, instr_word[5:4]};
		irq_ok = irq_s.irq && (irq_s.lvl > s.stat[STAT_MASK_LSB +: 4]);
		a_addr = '0;
		a_we = 1'b0;
		a_wd = '0;
		a_last = 2'd0;
		a_need = 1'b1;
		// Access wanted by the current sequence step.
		case (s.seq)
			SQ_RESET: begin
				a_addr = s.step[0] ? RST_SP_ADDR : RST_PC_ADDR;
				a_last = 2'd1;
			end
			SQ_EXC: begin
				a_addr = (s.step == 2'd2) ? s.vbase + {22'h0, s.vec, 2'b00} : sp - STEP_WORD;
				a_we = (s.step != 2'd2);
				a_wd = (s.step == 2'd0) ? s.stat : s.tmp;
				a_last = 2'd2;
			end
			SQ_RTE: begin
				a_addr = sp;
				a_last = 2'd1;
			end
			SQ_LOAD: a_addr = s.gpr[s.rn];
			SQ_STORE: begin
				a_addr = s.gpr[s.rn] - STEP_WORD;
				a_we = 1'b1;
				a_wd = ctl_rd(s, s.idx);
			end
			default: a_need = 1'b0;
		endcase
		case (s.ps)
			PS_RESET: begin
				n = seq_go(s, SQ_RESET, CYC_EXC, 4'h0, 3'h0);
				n.ins = 1'b0;
				n.proc = PROC_EXC;
			end
			PS_EXEC: begin
				if (irq_s.nmi && !s.slot) begin
					n = exc_go(s, NMI_VEC, s.pc, CYC_EXC, 1'b0);
					n.iack = 1'b1;
				end else if (irq_ok && !s.slot) begin
					n = exc_go(s, irq_s.vec, s.pc, CYC_EXC, 1'b0);
					n.iack = 1'b1;
				end else if (instr_valid && s.rdy) begin
					take = 1'b1;
					n.done = 1'b1;
					n.pc = npc;
					n.slot = 1'b0;
					case (instr_word)
						OP_FLAG_CLEAR: n.stat[0] = 1'b0;
						OP_FLAG_SET: n.stat[0] = 1'b1;
						OP_ZERO_ACC: begin
							n.acc_hi = '0;
							n.acc_lo = '0;
							n.macu = 1'b0;
						end
						OP_NOP: ;
						OP_EXC_RETURN: n = seq_go(s, SQ_RTE, CYC_RTE, 4'h0, 3'h0);
						OP_SLEEP: n = seq_go(s, SQ_SLEEP, CYC_SLEEP, 4'h0, 3'h0);
						default: begin
							if (instr_word[15:8] == OP_TRAP_HI) begin
								n = exc_go(s, instr_word[7:0], npc, CYC_TRAP, 1'b1);
							end else if (instr_word[7:6] == 2'b00 && instr_word[5:4] != 2'b11) begin
								case ({instr_word[15:12], instr_word[3:0]})
									8'h4e: n = ctl_wr(n, cc, s.gpr[r]);
									8'h4a: n = ctl_wr(n, cs, s.gpr[r]);
									8'h47: n = seq_go(s, SQ_LOAD, CYC_LDC_MEM, r, cc);
									8'h46: n = seq_go(s, SQ_LOAD, CYC_LDS_MEM, r, cs);
									8'h43: n = seq_go(s, SQ_STORE, CYC_STC_MEM, r, cc);
									8'h42: n = seq_go(s, SQ_STORE, CYC_STS_MEM, r, cs);
									8'h02: n.gpr[r] = ctl_rd(s, cc);
									8'h0a: n.gpr[r] = ctl_rd(s, cs);
									default: ;
								endcase
							end
						end
					endcase
				end
			end
			PS_SEQ: begin
				if (s.cyc != 4'hf) begin
					n.cyc = s.cyc + 4'h1;
				end
				if (a_need && !s.mfin) begin
					if (!s.mreq.req) begin
						n.mreq = '{req: 1'b1, we: a_we, addr: a_addr, wdata: a_wd};
					end else if (mem_rsp.ack) begin
						n.mreq.req = 1'b0;
						if (s.step == a_last) begin
							n.mfin = 1'b1;
						end else begin
							n.step = s.step + 2'd1;
						end
						case (s.seq)
							SQ_RESET: begin
								if (s.step == 2'd0) begin
									n.pc = mem_rsp.rdata;
								end else begin
									n.gpr[SP_IDX] = mem_rsp.rdata;
								end
							end
							SQ_EXC: begin
								if (s.step == 2'd2) begin
									n.pc = mem_rsp.rdata;
								end else begin
									n.gpr[SP_IDX] = a_addr;
								end
							end
							SQ_RTE: begin
								n.gpr[SP_IDX] = sp + STEP_WORD;
								if (s.step == 2'd0) begin
									n.tmp = mem_rsp.rdata;
								end else begin
									n.stat = mem_rsp.rdata;
								end
							end
							SQ_LOAD: begin
								n.gpr[s.rn] = s.gpr[s.rn] + STEP_WORD;
								n = ctl_wr(n, s.idx, mem_rsp.rdata);
							end
							default: n.gpr[s.rn] = a_addr;
						endcase
					end
				end else if ({1'b0, s.cyc} + 5'h01 >= {1'b0, s.minc}) begin // Five bits: a saturated count still ends.
					n.ps = PS_EXEC;
					n.proc = PROC_EXEC;
					n.done = s.ins;
					case (s.seq)
						SQ_RTE: begin
							n.pc = s.pc + INSTR_BYTES;
							n.slot = 1'b1;
							n.slot_pc = s.tmp;
						end
						SQ_LOAD, SQ_STORE: begin
							n.pc = npc;
							n.slot = 1'b0;
						end
						SQ_SLEEP: begin
							n.pc = npc;
							n.slot = 1'b0;
							n.proc = PROC_PDOWN;
							n.ps = standby_select_bit ? PS_STANDBY : PS_SLEEP;
							n.macu = s.macu | (standby_select_bit & mult_busy);
						end
						default: ;
					endcase
				end
			end
			PS_SLEEP: begin
				if (irq_s.nmi || irq_ok) begin
					n = exc_go(s, irq_s.nmi ? NMI_VEC : irq_s.vec, s.pc, CYC_EXC, 1'b0);
					n.iack = 1'b1;
				end
			end
			PS_STANDBY: begin
				if (irq_s.nmi) begin
					n.ps = PS_OSC;
					n.ocnt = '0;
				end
			end
			PS_OSC: begin
				n.ocnt = s.ocnt + 16'h1;
				if (s.ocnt == 16'(OSC_CYC - 1)) begin
					n = exc_go(s, NMI_VEC, s.pc, CYC_EXC, 1'b0);
					n.iack = 1'b1;
				end
			end
			default: n.ps = PS_RESET;
		endcase
		n.rdy = (n.ps == PS_EXEC) && !take;
		n.sleep = (n.ps == PS_SLEEP);
		n.stby = (n.ps == PS_STANDBY);
	end

	//------------------------------------------------------------
	// State register and outputs
	//------------------------------------------------------------
	// Registers the whole state; reset gives the reset processing state.
	always_ff @(posedge core_clk or negedge rst_s) begin
		if (!rst_s) begin
			s <= '0;
			s.stat <= STAT_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs come straight from the state register.
	assign mem_cmd = s.mreq;
	assign proc_state = s.proc;
	assign pc_value = s.pc;
	assign status_word = s.stat;
	assign instr_ready = s.rdy;
	assign instr_done = s.done;
	assign irq_ack = s.iack;
	assign sleep_mode = s.sleep;
	assign standby_mode = s.stby;
	assign mac_uncertain = s.macu;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	sequence sleep_taken;
		take && instr_word == OP_SLEEP;
	endsequence
	sequence quiet_two;
		(!s.sleep && !s.stby) [*2];
	endsequence

	ready_exec_a: assert property (s.rdy |-> s.proc == PROC_EXEC && s.ps == PS_EXEC)
		else $error("ready outside program execution");
	reset_fetch_a: assert property ($rose(s.mreq.req) && s.seq == SQ_RESET && s.step == 2'd0
		|-> s.mreq.addr == RST_PC_ADDR && !s.mreq.we)
		else $error("reset fetch address wrong");
	exc_push_a: assert property ($rose(s.mreq.req) && s.seq == SQ_EXC && s.step == 2'd0
		|-> s.mreq.we && s.mreq.addr == sp - STEP_WORD && s.mreq.wdata == s.stat)
		else $error("status word push wrong");
	exc_exec_a: assert property (s.ps == PS_SEQ && n.ps != PS_SEQ && s.seq == SQ_EXC
		|=> s.ps == PS_EXEC && s.proc == PROC_EXEC)
		else $error("no execution after exception");
	sleep_min_a: assert property (sleep_taken |=> quiet_two)
		else $error("low power entered too early");
	sleep_wake_a: assert property (s.ps == PS_SLEEP && (irq_s.nmi || irq_ok)
		|=> s.ps == PS_SEQ && s.seq == SQ_EXC && s.iack)
		else $error("sleep wake missed");
	standby_hold_a: assert property (s.ps == PS_STANDBY && !irq_s.nmi |=> s.ps == PS_STANDBY)
		else $error("standby left without NMI");
	rte_cycles_a: assert property (take && instr_word == OP_EXC_RETURN |=> !s.done [*3])
		else $error("return too short");
	trap_cycles_a: assert property (take && instr_word[15:8] == OP_TRAP_HI |=> !s.done [*7])
		else $error("trap too short");
	acc_clear_a: assert property (take && instr_word == OP_ZERO_ACC
		|=> s.acc_hi == '0 && s.acc_lo == '0 && s.stat[0] == $past(s.stat[0]))
		else $error("accumulator clear wrong");
	flag_clear_a: assert property (take && instr_word == OP_FLAG_CLEAR |=> !s.stat[0] && s.done)
		else $error("flag clear failed");
endmodule
`default_nettype wire

//--- hdl/scx_pkg.sv
// Shared types and constants of the system-control executor.
// Assumes one 100 MHz core clock and a 32-bit byte-addressed memory bus.
package scx_pkg;

	// Clock and oscillator timing.
	localparam int CLK_PERIOD_NS = 10;
	localparam int OSC_STAB_NS = 10000;
	localparam int OSC_STAB_CYC = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Vector table and reset values.
	localparam logic [31:0] RST_PC_ADDR = 32'h0000_0000;
	localparam logic [31:0] RST_SP_ADDR = 32'h0000_0004;
	localparam logic [31:0] STAT_RST = 32'h0000_00f0;
	localparam logic [7:0] NMI_VEC = 8'h0b;
	localparam int STAT_MASK_LSB = 4;
	localparam logic [3:0] SP_IDX = 4'hf;
	localparam logic [31:0] STEP_WORD = 32'h0000_0004;
	localparam logic [31:0] INSTR_BYTES = 32'h0000_0002;

	// Least execution cycles.
	localparam logic [3:0] CYC_EXC = 4'h1;
	localparam logic [3:0] CYC_RTE = 4'h4;
	localparam logic [3:0] CYC_TRAP = 4'h8;
	localparam logic [3:0] CYC_SLEEP = 4'h3;
	localparam logic [3:0] CYC_LDC_MEM = 4'h3;
	localparam logic [3:0] CYC_LDS_MEM = 4'h1;
	localparam logic [3:0] CYC_STC_MEM = 4'h2;
	localparam logic [3:0] CYC_STS_MEM = 4'h1;

	// Fixed operation words.
	localparam logic [15:0] OP_FLAG_CLEAR = 16'h0008;
	localparam logic [15:0] OP_FLAG_SET = 16'h0018;
	localparam logic [15:0] OP_ZERO_ACC = 16'h0028;
	localparam logic [15:0] OP_NOP = 16'h0009;
	localparam logic [15:0] OP_EXC_RETURN = 16'h002b;
	localparam logic [15:0] OP_SLEEP = 16'h001b;
	localparam logic [7:0] OP_TRAP_HI = 8'hc3;

	// Control register index: 0..2 control group, 3..5 system group.
	localparam logic [2:0] CR_STATUS = 3'h0;
	localparam logic [2:0] CR_GLOBAL = 3'h1;
	localparam logic [2:0] CR_VECTOR = 3'h2;
	localparam logic [2:0] CR_ACC_HI = 3'h3;
	localparam logic [2:0] CR_ACC_LO = 3'h4;
	localparam logic [2:0] CR_LINK = 3'h5;

	typedef enum logic [2:0] {PS_RESET, PS_EXEC, PS_SEQ, PS_SLEEP, PS_STANDBY, PS_OSC} scx_ps_t;
	typedef enum logic [2:0] {SQ_RESET, SQ_EXC, SQ_RTE, SQ_LOAD, SQ_STORE, SQ_SLEEP} scx_seq_t;
	typedef enum logic [1:0] {PROC_RESET, PROC_EXC, PROC_EXEC, PROC_PDOWN} scx_proc_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} scx_mem_req_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} scx_mem_rsp_t;

	typedef struct packed {
		logic nmi;
		logic irq;
		logic [3:0] lvl;
		logic [7:0] vec;
	} scx_irq_t;

	typedef struct packed {
		scx_ps_t ps;
		scx_seq_t seq;
		scx_proc_t proc;
		logic [1:0] step;
		logic [3:0] cyc;
		logic [3:0] minc;
		logic mfin;
		logic [3:0] rn;
		logic [2:0] idx;
		logic [7:0] vec;
		logic ins;
		logic slot;
		logic [31:0] slot_pc;
		logic [31:0] tmp;
		logic [31:0] pc;
		logic [31:0] stat;
		logic [31:0] gbase;
		logic [31:0] vbase;
		logic [31:0] acc_hi;
		logic [31:0] acc_lo;
		logic [31:0] link;
		logic [15:0][31:0] gpr;
		scx_mem_req_t mreq;
		logic done;
		logic iack;
		logic rdy;
		logic sleep;
		logic stby;
		logic macu;
		logic [15:0] ocnt;
	} scx_state_t;

endpackage

//--- hdl/scx_sync.sv
// Two-stage synchroniser for pin-level inputs.
// Assumes the destination clock and an active-low asynchronous reset.
`timescale 1ns/100ps
`default_nettype none
module scx_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk, // Destination clock.
	input wire logic rst_b, // Asynchronous reset, active low.
	input wire logic [WIDTH-1:0] d, // Asynchronous input.
	output logic [WIDTH-1:0] q // Synchronised copy.
);
	logic [WIDTH-1:0] meta_r;

	// The first stage feeds only the second stage.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- sim/scx_mem_model.sv
// Memory bus partner: vectors, stack and program data in one sparse array.
// Assumes the core holds each request until acknowledged and idles between.
`timescale 1ns/100ps
`default_nettype none
module scx_mem_model (
	input wire logic core_clk, // System clock.
	input wire logic rst_b, // Reset, active low.
	input wire scx_pkg::scx_mem_req_t mem_cmd, // Request from the core.
	output scx_pkg::scx_mem_rsp_t mem_rsp, // Acknowledge and read data.
	output logic [31:0] last_raddr, // Address of the latest read.
	output logic [31:0] last_waddr, // Address of the latest write.
	output logic [31:0] last_wdata // Data of the latest write.
);
	import scx_pkg::*;
	logic [31:0] mem [logic [31:0]];
	int wait_n;
	int dly;
	int seed = 32'h9f7a937d;

	// Answers after a random wait; idle read data toggles so stale data never matches.
	// memory wait states
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_rsp <= '0;
			wait_n <= 0;
			dly <= 0;
		end else if (mem_rsp.ack) begin
			mem_rsp.ack <= 1'b0;
			mem_rsp.rdata <= ~mem_rsp.rdata;
			dly <= $unsigned($random(seed)) % 3;
		end else if (mem_cmd.req && wait_n >= dly) begin
			mem_rsp.ack <= 1'b1;
			wait_n <= 0;
			if (mem_cmd.we) begin
				mem[mem_cmd.addr] = mem_cmd.wdata;
				last_waddr <= mem_cmd.addr;
				last_wdata <= mem_cmd.wdata;
				mem_rsp.rdata <= ~mem_rsp.rdata;
			end else begin
				last_raddr <= mem_cmd.addr;
				mem_rsp.rdata <= mem.exists(mem_cmd.addr) ? mem[mem_cmd.addr] : ~mem_cmd.addr;
			end
		end else begin
			wait_n <= mem_cmd.req ? wait_n + 1 : 0;
			mem_rsp.rdata <= ~mem_rsp.rdata;
		end
	end
endmodule
`default_nettype wire

//--- sim/tb_cpu_sysctl_and_power_states.sv
// Self-checking bench of the system-control executor with a memory partner.
// Assumes scx_core is the top design module and the vector base starts at zero.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_cpu_sysctl_and_power_states;
	import scx_pkg::*;
	localparam int OSC = 4;
	localparam logic [31:0] START_PC = 32'h0000_0100;
	localparam logic [31:0] INIT_SP = 32'h0000_1000;
	logic core_clk = 1'b0;
	logic rst_b;
	logic instr_valid;
	logic [15:0] instr_word;
	scx_mem_rsp_t mem_rsp;
	scx_irq_t irq_pins;
	logic standby_select_bit;
	logic mult_busy;
	scx_mem_req_t mem_cmd;
	scx_proc_t proc_state;
	logic [31:0] pc_value, status_word, last_raddr, last_waddr, last_wdata;
	logic instr_ready, instr_done, irq_ack, sleep_mode, standby_mode, mac_uncertain;
	int bad_count = 0;
	int comparisons = 0;
	int seed = 32'h9f7a937d;
	int cyc;
	int k;
	logic [31:0] sp, val, hnd, pcx;
	logic [7:0] vv;
	logic flag;
	logic [15:0] ops [3] = '{OP_FLAG_CLEAR, OP_FLAG_SET, OP_NOP};

	// Clock of 100 MHz.
	always #5 core_clk = ~core_clk;

	scx_core #(.OSC_CYC(OSC)) DUT (.core_clk(core_clk), .rst_b(rst_b), .instr_valid(instr_valid),
		.instr_word(instr_word), .mem_rsp(mem_rsp), .irq_pins(irq_pins),
		.standby_select_bit(standby_select_bit), .mult_busy(mult_busy), .mem_cmd(mem_cmd),
		.proc_state(proc_state), .pc_value(pc_value), .status_word(status_word),
		.instr_ready(instr_ready), .instr_done(instr_done), .irq_ack(irq_ack),
		.sleep_mode(sleep_mode), .standby_mode(standby_mode), .mac_uncertain(mac_uncertain));
	scx_mem_model mdl (.core_clk(core_clk), .rst_b(rst_b), .mem_cmd(mem_cmd), .mem_rsp(mem_rsp),
		.last_raddr(last_raddr), .last_waddr(last_waddr), .last_wdata(last_wdata));

	// Prints the verdict and ends the run.
	task automatic finish_test();
		if (bad_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Counts falling edges until a design flag is high, with a bound.
	task automatic wait_hi(ref logic s);
		cyc = 0;
		while (s !== 1'b1) begin
			@(negedge core_clk);
			cyc++;
			if (cyc > 600) begin
				bad_count++;
				finish_test();
			end
		end
	endtask

	// Offers one instruction, holds it until done; cyc is take-to-done cycles.
	task automatic run(input logic [15:0] op);
		@(negedge core_clk);
		instr_valid = 1'b1;
		instr_word = op;
		wait_hi(instr_ready);
		@(negedge core_clk);
		wait_hi(instr_done);
		cyc++;
		instr_valid = 1'b0;
	endtask

	// Cuts a hang short.
	initial begin
		#(50000 * 10);
		bad_count++;
		finish_test();
	end

	// Main sequence.
	initial begin
		rst_b = 1'b0;
		instr_valid = 1'b0;
		instr_word = '0;
		irq_pins = '0;
		standby_select_bit = 1'b0;
		mult_busy = 1'b0;
		#1;
		mdl.mem[32'h0] = START_PC;
		mdl.mem[32'h4] = INIT_SP;
		repeat (12) @(negedge core_clk);
		`CHK("reset state", PROC_RESET, proc_state)
		`CHK("reset status", STAT_RST, status_word)
		rst_b = 1'b1;
		wait_hi(instr_ready);
		`CHK("start pc", START_PC, pc_value)
		`CHK("exec state", PROC_EXEC, proc_state)
		sp = INIT_SP;
		for (int i = 0; i < 12; i++) begin
			k = $unsigned($random(seed)) % 3;
			flag = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : status_word[0];
			pcx = pc_value + 32'h2;
			run(ops[k]);
			`CHK("flag op cycles", 1'b1, cyc == 1)
			`CHK("test flag", flag, status_word[0])
			`CHK("pc advance", pcx, pc_value)
		end
		val = status_word;
		run(16'h4f03);
		sp = sp - 32'h4;
		`CHK("store ctl cycles", 1'b1, cyc >= 2)
		`CHK("store ctl addr", sp, last_waddr)
		`CHK("store ctl data", val, last_wdata)
		val = $random(seed) & 32'hffff_ff0f;
		mdl.mem[sp] = val;
		run(16'h4f07);
		`CHK("load ctl cycles", 1'b1, cyc >= 3)
		`CHK("load ctl addr", sp, last_raddr)
		`CHK("status flag", val[0], status_word[0])
		sp = sp + 32'h4;
		val = $random(seed);
		mdl.mem[sp] = val;
		run(16'h4f16);
		`CHK("load acc addr", sp, last_raddr)
		run(16'h4f12);
		`CHK("store acc addr", sp, last_waddr)
		`CHK("store acc data", val, last_wdata)
		run(16'h4f06);
		flag = status_word[0];
		run(OP_ZERO_ACC);
		`CHK("zero acc cycles", 1'b1, cyc == 1)
		`CHK("zero acc flag", flag, status_word[0])
		run(16'h4f02);
		`CHK("acc high zero", 32'h0, last_wdata)
		run(16'h4f12);
		sp = sp - 32'h4;
		`CHK("acc low zero", 32'h0, last_wdata)
		vv = 8'h20 + 8'($unsigned($random(seed)) % 32);
		hnd = ($random(seed) & 32'h0000_fff0) | 32'h0001_0000;
		mdl.mem[{22'h0, vv, 2'b00}] = hnd;
		run({OP_TRAP_HI, vv});
		sp = sp - 32'h8;
		`CHK("trap cycles", 1'b1, cyc >= 8)
		`CHK("trap target", hnd, pc_value)
		`CHK("trap push", sp, last_waddr)
		pcx = hnd + 32'h40;
		val = $random(seed) & 32'hffff_ff0f;
		mdl.mem[sp] = pcx;
		mdl.mem[sp + 32'h4] = val;
		run(OP_EXC_RETURN);
		`CHK("return cycles", 1'b1, cyc >= 4)
		run(OP_NOP);
		sp = sp + 32'h8;
		`CHK("return pc", pcx, pc_value)
		`CHK("return flag", val[0], status_word[0])
		run(OP_SLEEP);
		`CHK("sleep cycles", 1'b1, cyc >= 3)
		`CHK("sleep entry", 1'b1, sleep_mode)
		`CHK("power down", PROC_PDOWN, proc_state)
		pcx = pc_value;
		repeat (6) @(negedge core_clk);
		`CHK("sleep halts pc", pcx, pc_value)
		vv = 8'h40 + 8'($unsigned($random(seed)) % 32);
		hnd = ($random(seed) & 32'h0000_fff0) | 32'h0002_0000;
		mdl.mem[{22'h0, vv, 2'b00}] = hnd;
		irq_pins = '{nmi: 1'b0, irq: 1'b1, lvl: 4'hf, vec: vv};
		wait_hi(irq_ack);
		irq_pins = '0;
		wait_hi(instr_ready);
		`CHK("irq wake pc", hnd, pc_value)
		`CHK("irq wake mode", 1'b0, sleep_mode)
		mult_busy = 1'b1;
		standby_select_bit = 1'b1;
		run(OP_SLEEP);
		mult_busy = 1'b0;
		`CHK("standby entry", 1'b1, standby_mode)
		`CHK("acc uncertain", 1'b1, mac_uncertain)
		irq_pins = '{nmi: 1'b0, irq: 1'b1, lvl: 4'hf, vec: vv};
		repeat (12) @(negedge core_clk);
		`CHK("irq no wake", 1'b1, standby_mode)
		hnd = ($random(seed) & 32'h0000_fff0) | 32'h0003_0000;
		mdl.mem[{22'h0, NMI_VEC, 2'b00}] = hnd;
		irq_pins = '{nmi: 1'b1, irq: 1'b0, lvl: 4'h0, vec: 8'h0};
		wait_hi(irq_ack);
		`CHK("osc wait", 1'b1, cyc >= OSC)
		irq_pins = '0;
		standby_select_bit = 1'b0;
		wait_hi(instr_ready);
		`CHK("nmi wake pc", hnd, pc_value)
		run(OP_ZERO_ACC);
		`CHK("acc defined", 1'b0, mac_uncertain)
		rst_b = 1'b0;
		repeat (2) @(negedge core_clk);
		`CHK("mid reset", PROC_RESET, proc_state)
		rst_b = 1'b1;
		wait_hi(instr_ready);
		`CHK("restart pc", START_PC, pc_value)
		finish_test();
	end
endmodule
`default_nettype wire
